/* logic/dc_motor_cascade_loop.sv */
// cascaded speed and current loop for a brushed dc motor
`timescale 1ns/1ps
`default_nettype none
`include "motor_loop_map.svh"
// Summary of operation
// - master turns voltage into duty, updates phases
// - phase duty spans fully off to on
// - only phase generators drive motor pins
// - decode sector from three hall inputs
// - direction zero positive, nonzero negative
// - revolution count up or down per turn
// - revolution period between same-polarity edges
// - sector period between last two changes
// - timestamp of latest hall edge kept
// - speed reference comes from the ramp
// - speed from hall period, pi on error
// - current pi outputs applied voltage
// - sampler synchronised to pwm period start
// - speed loop started every sixteenth sample
// - current loop started each sample period
// - sample shifted, filtered, fed to current
// - disable stops pwm and both regulators
// - host speed goes into ramp input
// - quantities are signed 1.23 fractions
// - conversion request quarter period, falling edge
module dc_motor_cascade_loop #(
  parameter int PERIOD_W = 16
) (
  input wire logic mclk, // timebase clock
  input wire logic rst_n, // synchronous reset
  input wire logic [3:0] reg_addr, // register index
  input wire logic [23:0] reg_wdata, // write data
  input wire logic reg_wr, // write strobe
  input wire logic reg_rd, // read strobe
  output logic [23:0] reg_rdata, // read data, next cycle
  input wire logic [2:0] hall_in, // hall sensor levels
  input wire logic conv_done, // converter result ready
  input wire logic [15:0] conv_result, // raw bus-current result
  output logic conv_req, // dma request, falling edge pin
  output logic sample_pin, // sampler pulse pin, active low
  output logic phase_a, // phase a pwm
  output logic phase_b // phase b pwm
);
  typedef motor_loop_pkg::frac_t frac_t;

  function automatic frac_t sat(input logic signed [31:0] v);
    if (v > $signed({8'h00, `FRAC_MAX})) sat = frac_t'(`FRAC_MAX);
    else if (v < $signed({8'hFF, `FRAC_MIN})) sat = frac_t'(`FRAC_MIN);
    else sat = v[23:0];
  endfunction

  // 9.15 gain times 1.23 value
  function automatic logic signed [31:0] gmul(input frac_t g, input frac_t x);
    logic signed [47:0] p;
    p = g * x;
    gmul = p[46:15];
  endfunction

  motor_loop_pkg::reg_req_t req;
  assign req = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};

  // registers
  logic [23:0] ctrl_q, ctrl_d;
  frac_t speed_req_q, speed_req_d, skp_q, skp_d, ski_q, ski_d, ckp_q, ckp_d, cki_q, cki_d;
  logic [PERIOD_W-1:0] period_q, period_d, width_q, width_d;
  logic [23:0] rdata_q, rdata_d;
  logic enable;
  assign enable = ctrl_q[`CTRL_ENABLE];

  // hall decoder state
  motor_loop_pkg::hall_state_t hs_q, hs_d;
  logic [2:0] hall_q, hall_d;
  logic [23:0] tb_q, tb_d, rev_cnt_q, rev_cnt_d;
  logic [23:0] rise_t_q [3], rise_t_d [3], fall_t_q [3], fall_t_d [3];
  // pwm and sampler
  logic [PERIOD_W-1:0] pcnt_q, pcnt_d, duty_q, duty_d;
  logic pa_q, pa_d, pb_q, pb_d;
  motor_loop_pkg::smp_state_t smp_q, smp_d;
  logic [3:0] div_q, div_d;
  logic req_q, req_d, pin_q, pin_d;
  frac_t filt_q, filt_d;
  logic [15:0] raw_q, raw_d;

  // regulators
  frac_t ramp_q, ramp_d, speed_meas_q, speed_meas_d, sint_q, sint_d, cur_ref_q, cur_ref_d;
  frac_t cint_q, cint_d, volt_q, volt_d;
  logic speed_go_q, speed_go_d, cur_go_q, cur_go_d;

  // register file
  always_comb begin
    ctrl_d = ctrl_q;
    speed_req_d = speed_req_q;
    skp_d = skp_q;
    ski_d = ski_q;
    ckp_d = ckp_q;
    cki_d = cki_q;
    period_d = period_q;
    width_d = width_q;
    rdata_d = 24'h00_0000;
    if (req.wr) begin
      case (req.addr)
        `ADDR_CTRL: ctrl_d = req.wdata;
        `ADDR_SPEED_REQ: speed_req_d = req.wdata;
        `ADDR_SPEED_KP: skp_d = req.wdata;
        `ADDR_SPEED_KI: ski_d = req.wdata;
        `ADDR_CUR_KP: ckp_d = req.wdata;
        `ADDR_CUR_KI: cki_d = req.wdata;
        `ADDR_PWM_PERIOD: period_d = req.wdata[PERIOD_W-1:0];
        `ADDR_SAMPLE_WIDTH: width_d = req.wdata[PERIOD_W-1:0];
        default: ;
      endcase
    end
    if (req.rd) begin
      case (req.addr)
        `ADDR_CTRL: rdata_d = ctrl_q;
        `ADDR_SPEED_REQ: rdata_d = speed_req_q;
        `ADDR_SPEED_KP: rdata_d = skp_q;
        `ADDR_SPEED_KI: rdata_d = ski_q;
        `ADDR_CUR_KP: rdata_d = ckp_q;
        `ADDR_CUR_KI: rdata_d = cki_q;
        `ADDR_PWM_PERIOD: rdata_d = 24'(period_q);
        `ADDR_SAMPLE_WIDTH: rdata_d = 24'(width_q);
        `ADDR_STATUS: rdata_d = {19'h0_0000, hs_q.direction, hs_q.sector, enable};
        `ADDR_REV_COUNT: rdata_d = rev_cnt_q;
        `ADDR_REV_PERIOD: rdata_d = hs_q.rev_period;
        `ADDR_SECTOR_PERIOD: rdata_d = hs_q.sector_period;
        `ADDR_LAST_EDGE: rdata_d = hs_q.last_edge;
        `ADDR_SPEED_MEAS: rdata_d = speed_meas_q;
        `ADDR_CUR_MEAS: rdata_d = filt_q;
        `ADDR_VOLT_OUT: rdata_d = volt_q;
        default: rdata_d = 24'h00_0000;
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      ctrl_q <= 24'h00_0000;
      speed_req_q <= `FRAC_ZERO;
      skp_q <= `GAIN_ONE;
      ski_q <= `FRAC_ZERO;
      ckp_q <= `GAIN_ONE;
      cki_q <= `FRAC_ZERO;
      period_q <= `PWM_PERIOD_RST;
      width_q <= `SAMPLE_WIDTH_RST;
      rdata_q <= 24'h00_0000;
    end else begin
      ctrl_q <= ctrl_d;
      speed_req_q <= speed_req_d;
      skp_q <= skp_d;
      ski_q <= ski_d;
      ckp_q <= ckp_d;
      cki_q <= cki_d;
      period_q <= period_d;
      width_q <= width_d;
      rdata_q <= rdata_d;
    end
  end
  assign reg_rdata = rdata_q;

  // hall sector decoder
  always_comb begin
    hs_d = hs_q;
    hall_d = hall_in;
    tb_d = tb_q + 24'h00_0001;
    rev_cnt_d = rev_cnt_q;
    rise_t_d = rise_t_q;
    fall_t_d = fall_t_q;
    if (hall_in != hall_q) begin
      hs_d.last_edge = tb_q;
      hs_d.sector = hall_in;
      hs_d.direction = ({hall_q[1:0], ~hall_q[2]} == hall_in) ? 1'b0 : 1'b1;
      hs_d.sector_period = tb_q - hs_q.last_edge;
      for (int i = 0; i < 3; i++) begin
        if (hall_in[i] != hall_q[i]) begin
          if (hall_in[i]) begin
            hs_d.rev_period = tb_q - rise_t_q[i];
            rise_t_d[i] = tb_q;
          end else begin
            hs_d.rev_period = tb_q - fall_t_q[i];
            fall_t_d[i] = tb_q;
          end
          // count per revolution on channel a rise
          if (i == 0 && hall_in[i])
            rev_cnt_d = hs_d.direction ? rev_cnt_q - 24'h00_0001 : rev_cnt_q + 24'h00_0001;
        end
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      hs_q <= '0;
      hall_q <= 3'h0;
      tb_q <= 24'h00_0000;
      rev_cnt_q <= 24'h00_0000;
      rise_t_q <= '{3{24'h00_0000}};
      fall_t_q <= '{3{24'h00_0000}};
    end else begin
      hs_q <= hs_d;
      hall_q <= hall_d;
      tb_q <= tb_d;
      rev_cnt_q <= rev_cnt_d;
      rise_t_q <= rise_t_d;
      fall_t_q <= fall_t_d;
    end
  end

  // pwm master, two full-range phases, sampler
  always_comb begin
    logic [PERIOD_W-1:0] quarter;
    logic [15:0] sh;
    logic [39:0] scaled;
    quarter = period_q >> 2;
    sh = raw_q;
    pcnt_d = (pcnt_q >= period_q - 1'b1) ? '0 : pcnt_q + 1'b1;
    // duty from applied voltage, loaded at period start
    duty_d = duty_q;
    scaled = {16'h0000, volt_q[23] ? 24'h00_0000 : volt_q} * {24'h00_0000, period_q};
    if (pcnt_q == '0) duty_d = (volt_q == frac_t'(`FRAC_MAX)) ? period_q : scaled[22+PERIOD_W:23];
    // full range: duty zero off, duty period always on
    // only the phases drive pins; off when disabled
    pa_d = enable && (pcnt_q < duty_q);
    pb_d = enable && !(pcnt_q < duty_q);
    smp_d = smp_q;
    req_d = 1'b0;
    pin_d = pin_q;
    div_d = div_q;
    filt_d = filt_q;
    cur_go_d = 1'b0;
    speed_go_d = 1'b0;
    raw_d = raw_q;
    case (smp_q)
      motor_loop_pkg::SMP_WAIT: begin
        // quarter period after start, falling edge
        if (enable && pcnt_q == quarter) begin
          req_d = 1'b1;
          pin_d = 1'b0;
          smp_d = motor_loop_pkg::SMP_CONV;
          speed_go_d = (div_q == `SPEED_DIV);
          div_d = div_q + 4'h1;
        end
      end
      motor_loop_pkg::SMP_CONV: begin
        // result bus only valid beside the done pulse
        if (conv_done) raw_d = conv_result;
        if (pcnt_q == quarter + width_q || conv_done) smp_d = motor_loop_pkg::SMP_PROC;
      end
      motor_loop_pkg::SMP_PROC: begin
        case (ctrl_q[`CTRL_SHIFT_LSB +: 2])
          2'b00: filt_d = filt_q + ((frac_t'({sh, 8'h00}) - filt_q) >>> ctrl_q[`CTRL_FILT_LSB +: 5]);
          2'b01: filt_d = filt_q + ((frac_t'({sh[13:0], 10'h000}) - filt_q) >>> ctrl_q[`CTRL_FILT_LSB +: 5]);
          2'b10: filt_d = filt_q + ((frac_t'({sh[11:0], 12'h000}) - filt_q) >>> ctrl_q[`CTRL_FILT_LSB +: 5]);
          default: filt_d = filt_q + ((frac_t'({sh[7:0], 16'h0000}) - filt_q) >>> ctrl_q[`CTRL_FILT_LSB +: 5]);
        endcase
        pin_d = 1'b1;
        cur_go_d = 1'b1;
        smp_d = motor_loop_pkg::SMP_WAIT;
      end
      default: smp_d = motor_loop_pkg::SMP_WAIT;
    endcase
    if (!enable) begin
      pin_d = 1'b1;
      smp_d = motor_loop_pkg::SMP_WAIT;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      pcnt_q <= '0;
      duty_q <= '0;
      pa_q <= 1'b0;
      pb_q <= 1'b0;
      smp_q <= motor_loop_pkg::SMP_WAIT;
      div_q <= 4'h0;
      req_q <= 1'b0;
      pin_q <= 1'b1;
      filt_q <= `FRAC_ZERO;
      raw_q <= 16'h0000;
      cur_go_q <= 1'b0;
      speed_go_q <= 1'b0;
    end else begin
      pcnt_q <= pcnt_d;
      duty_q <= duty_d;
      pa_q <= pa_d;
      pb_q <= pb_d;
      smp_q <= smp_d;
      div_q <= div_d;
      req_q <= req_d;
      pin_q <= pin_d;
      filt_q <= filt_d;
      raw_q <= raw_d;
      cur_go_q <= cur_go_d;
      speed_go_q <= speed_go_d;
    end
  end
  // dma chain starts from this request
  assign conv_req = req_q;
  assign sample_pin = pin_q;
  assign phase_a = pa_q;
  assign phase_b = pb_q;

  // speed and current regulators
  always_comb begin
    frac_t e;
    logic [47:0] q;
    e = '0;
    q = '0;
    ramp_d = ramp_q;
    speed_meas_d = speed_meas_q;
    sint_d = sint_q;
    cur_ref_d = cur_ref_q;
    cint_d = cint_q;
    volt_d = volt_q;
    if (speed_go_q) begin
      if ($signed(speed_req_q) > $signed(ramp_q) + $signed({16'h0000, ctrl_q[`CTRL_RAMP_LSB +: 8]}))
        ramp_d = ramp_q + {16'h0000, ctrl_q[`CTRL_RAMP_LSB +: 8]};
      else if ($signed(speed_req_q) < $signed(ramp_q) - $signed({16'h0000, ctrl_q[`CTRL_RAMP_LSB +: 8]}))
        ramp_d = ramp_q - {16'h0000, ctrl_q[`CTRL_RAMP_LSB +: 8]};
      else ramp_d = speed_req_q;
      q = (hs_q.rev_period == 24'h00_0000) ? 48'h0000_0000_0000 :
          48'(`FRAC_MAX) * 48'(`SPEED_SCALE) / 48'(hs_q.rev_period);
      // clamp before the signed cut so a fast motor cannot wrap
      if (q > 48'(`FRAC_MAX)) q = 48'(`FRAC_MAX);
      speed_meas_d = sat(hs_q.direction ? -$signed(32'(q)) : $signed(32'(q)));
      e = sat($signed(32'(ramp_q)) - $signed(32'(speed_meas_q)));
      sint_d = sat($signed(32'(sint_q)) + gmul(ski_q, e));
      cur_ref_d = sat($signed(32'(sint_d)) + gmul(skp_q, e));
    end
    if (cur_go_q) begin
      e = sat($signed(32'(cur_ref_q)) - $signed(32'(filt_q)));
      cint_d = sat($signed(32'(cint_q)) + gmul(cki_q, e));
      volt_d = sat($signed(32'(cint_d)) + gmul(ckp_q, e));
    end
    if (!enable) begin
      sint_d = `FRAC_ZERO;
      cint_d = `FRAC_ZERO;
      volt_d = `FRAC_ZERO;
      ramp_d = `FRAC_ZERO;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      ramp_q <= `FRAC_ZERO;
      speed_meas_q <= `FRAC_ZERO;
      sint_q <= `FRAC_ZERO;
      cur_ref_q <= `FRAC_ZERO;
      cint_q <= `FRAC_ZERO;
      volt_q <= `FRAC_ZERO;
    end else begin
      ramp_q <= ramp_d;
      speed_meas_q <= speed_meas_d;
      sint_q <= sint_d;
      cur_ref_q <= cur_ref_d;
      cint_q <= cint_d;
      volt_q <= volt_d;
    end
  end

  AST_DISABLE_IDLE: assert property (@(posedge mclk) disable iff (!rst_n)
    !enable |=> !phase_a && !phase_b) else $error("phase driven while disabled");
  AST_REQ_PULSE: assert property (@(posedge mclk) disable iff (!rst_n)
    conv_req |-> !sample_pin ##1 !conv_req) else $error("request not a lone pulse");
  AST_CUR_AFTER: assert property (@(posedge mclk) disable iff (!rst_n)
    smp_q == motor_loop_pkg::SMP_PROC && enable |=> cur_go_q) else $error("current loop not started");
  AST_SPEED_SYNC: assert property (@(posedge mclk) disable iff (!rst_n)
    speed_go_q |-> conv_req) else $error("speed loop start unsynchronised");
  AST_EDGE_STAMP: assert property (@(posedge mclk) disable iff (!rst_n)
    hall_in != hall_q |=> hs_q.last_edge == $past(tb_q)) else $error("edge time wrong");
  AST_SECTOR: assert property (@(posedge mclk) disable iff (!rst_n)
    hall_in != hall_q |=> hs_q.sector == $past(hall_in)) else $error("sector wrong");
  AST_PHASES: assert property (@(posedge mclk) disable iff (!rst_n)
    enable && $past(enable) |-> phase_a != phase_b) else $error("phases not complementary");
  // both integrators cleared to zero the cycle after halting
  AST_HALT_INT: assert property (@(posedge mclk) disable iff (!rst_n)
    !enable |=> cint_q == `FRAC_ZERO && sint_q == `FRAC_ZERO) else $error("integrator kept");
endmodule // dc_motor_cascade_loop
`default_nettype wire

/* pkg/motor_loop_map.svh */
// register offsets, field positions, reset values and timing counts of the motor loop
`ifndef MOTOR_LOOP_MAP_SVH
`define MOTOR_LOOP_MAP_SVH
`define ADDR_CTRL 4'h0
`define ADDR_SPEED_REQ 4'h1
`define ADDR_SPEED_KP 4'h2
`define ADDR_SPEED_KI 4'h3
`define ADDR_CUR_KP 4'h4
`define ADDR_CUR_KI 4'h5
`define ADDR_PWM_PERIOD 4'h6
`define ADDR_SAMPLE_WIDTH 4'h7
`define ADDR_STATUS 4'h8
`define ADDR_REV_COUNT 4'h9
`define ADDR_REV_PERIOD 4'hA
`define ADDR_SECTOR_PERIOD 4'hB
`define ADDR_LAST_EDGE 4'hC
`define ADDR_SPEED_MEAS 4'hD
`define ADDR_CUR_MEAS 4'hE
`define ADDR_VOLT_OUT 4'hF
`define CTRL_ENABLE 0
`define CTRL_SHIFT_LSB 1
`define CTRL_FILT_LSB 3
`define CTRL_RAMP_LSB 8
`define FRAC_MAX 24'h7F_FFFF
`define FRAC_MIN 24'h80_0000
`define FRAC_ZERO 24'h00_0000
`define GAIN_ONE 24'h00_8000
`define SPEED_DIV 4'hF
`define PWM_PERIOD_RST 16'h09C4
`define SAMPLE_WIDTH_RST 16'h00C8
`define SHIFT_8 5'h08
`define SHIFT_10 5'h0A
`define SHIFT_12 5'h0C
`define SHIFT_16 5'h10
`define SPEED_SCALE 24'h00_0400
`endif

/* pkg/motor_loop_pkg.sv */
// shared types of the motor loop
package motor_loop_pkg;
  typedef logic signed [23:0] frac_t;
  typedef struct packed {
    logic [23:0] rev_period;
    logic [23:0] sector_period;
    logic [23:0] last_edge;
    logic [2:0] sector;
    logic direction;
  } hall_state_t;
  typedef struct packed {
    logic [3:0] addr;
    logic [23:0] wdata;
    logic wr;
    logic rd;
  } reg_req_t;
  typedef enum logic [1:0] {
    SMP_WAIT = 2'b00,
    SMP_CONV = 2'b01,
    SMP_PROC = 2'b10
  } smp_state_t;
endpackage

/* tb/conv_chain_model.sv */
// behavioural converter and dma chain answering the sampler request
`timescale 1ns/1ps
`default_nettype none
module conv_chain_model #(
  parameter int LAT = 3
) (
  input wire logic mclk, // clock
  input wire logic rst_n, // synchronous reset
  input wire logic conv_req, // chain start pulse
  input wire logic [15:0] sample_val, // value the converter returns
  output logic conv_done, // result ready pulse
  output logic [15:0] conv_result // result word
);
  int cnt;
  logic [15:0] last_q;
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      cnt <= 0;
      conv_done <= 1'b0;
      conv_result <= 16'hFFFF;
      last_q <= 16'h0000;
    end else begin
      conv_done <= 1'b0;
      // result bus not held once the pulse is over
      conv_result <= ~last_q;
      if (conv_req) begin
        cnt <= LAT;
      end else if (cnt > 1) begin
        cnt <= cnt - 1;
      end else if (cnt == 1) begin
        cnt <= 0;
        conv_done <= 1'b1;
        conv_result <= sample_val;
        last_q <= sample_val;
      end
    end
  end
endmodule // conv_chain_model
`default_nettype wire

/* tb/dc_motor_cascade_loop_tb.sv */
// self-checking bench of the cascaded motor loop
`timescale 1ns/1ps
`default_nettype none
`include "motor_loop_map.svh"
module dc_motor_cascade_loop_tb;
  localparam int N = 20;
  logic mclk, rst_n, reg_wr, reg_rd, conv_done, conv_req, sample_pin, phase_a, phase_b;
  logic [3:0] reg_addr;
  logic [23:0] reg_wdata, reg_rdata;
  logic [2:0] hall_in;
  logic [15:0] conv_result, sample_val;
  int n_errors = 0;
  int compares = 0;
  logic [2:0] fwd [6] = '{3'h1, 3'h3, 3'h7, 3'h6, 3'h4, 3'h0};
  logic [2:0] bwd [6] = '{3'h0, 3'h4, 3'h6, 3'h7, 3'h3, 3'h1};

  dc_motor_cascade_loop dut_u (.mclk(mclk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .hall_in(hall_in), .conv_done(conv_done), .conv_result(conv_result),
    .conv_req(conv_req), .sample_pin(sample_pin), .phase_a(phase_a), .phase_b(phase_b));
  conv_chain_model #(.LAT(3)) far_u (.mclk(mclk), .rst_n(rst_n), .conv_req(conv_req),
    .sample_val(sample_val), .conv_done(conv_done), .conv_result(conv_result));

  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end

  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [23:0] d);
    @(posedge mclk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, output logic [23:0] d);
    @(posedge mclk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask

  task automatic step(input logic [2:0] h);
    @(posedge mclk);
    hall_in <= h;
    repeat (N - 1) @(posedge mclk);
  endtask

  task automatic wait_req(output int cyc);
    cyc = 0;
    do begin
      @(posedge mclk);
      #1 cyc++;
    end while (conv_req !== 1'b1 && cyc < 500);
  endtask

  task automatic t_reset();
    logic [23:0] v;
    rd(`ADDR_PWM_PERIOD, v);
    chk(v, 24'h00_09C4);
    rd(`ADDR_SAMPLE_WIDTH, v);
    chk(v, 24'h00_00C8);
    wr(`ADDR_STATUS, 24'hFF_FFFF);
    rd(`ADDR_STATUS, v);
    chk({23'h0, v[0]}, 24'h00_0000);
    wr(`ADDR_SPEED_REQ, 24'h12_3456);
    rd(`ADDR_SPEED_REQ, v);
    chk(v, 24'h12_3456);
    chk({22'h0, phase_a, phase_b}, 24'h00_0000);
  endtask

  task automatic t_hall();
    logic [23:0] r0, c1, v;
    for (int i = 0; i < 7; i++) step(fwd[i % 6]);
    rd(`ADDR_REV_COUNT, r0);
    rd(`ADDR_LAST_EDGE, c1);
    for (int i = 1; i <= 12; i++) step(fwd[i % 6]);
    rd(`ADDR_REV_COUNT, v);
    chk(v, r0 + 24'h00_0002);
    rd(`ADDR_REV_PERIOD, v);
    chk(v, 24'(6 * N));
    rd(`ADDR_SECTOR_PERIOD, v);
    chk(v, 24'(N));
    rd(`ADDR_LAST_EDGE, v);
    chk({23'h0, v === c1}, 24'h00_0000);
    rd(`ADDR_STATUS, v);
    chk({23'h0, v[4]}, 24'h00_0000);
    for (int i = 0; i < 12; i++) step(bwd[i % 6]);
    rd(`ADDR_REV_COUNT, v);
    chk(v, r0);
    rd(`ADDR_STATUS, v);
    chk({23'h0, v[4]}, 24'h00_0001);
    chk({21'h0, v[3:1]}, 24'h00_0001);
    rd(`ADDR_REV_PERIOD, v);
    chk(v, 24'(6 * N));
  endtask

  task automatic t_enable();
    int c;
    wr(`ADDR_PWM_PERIOD, 24'h00_0028);
    wr(`ADDR_SAMPLE_WIDTH, 24'h00_0008);
    wr(`ADDR_CUR_KP, 24'h00_0000);
    wr(`ADDR_CUR_KI, 24'h00_0000);
    wr(`ADDR_CTRL, 24'h00_0001);
    wait_req(c);
    wait_req(c);
    chk(24'(c), 24'h00_0028);
    chk({23'h0, sample_pin}, 24'h00_0000);
    c = 0;
    while (sample_pin !== 1'b1 && c < 20) begin
      @(posedge mclk);
      #1 c++;
    end
    chk({23'h0, sample_pin}, 24'h00_0001);
    for (int i = 0; i < 40; i++) begin
      @(posedge mclk);
      #1 chk({23'h0, phase_b}, {23'h0, ~phase_a});
      chk({23'h0, phase_a}, 24'h00_0000);
    end
  endtask

  task automatic t_sample();
    logic [23:0] v;
    logic [4:0] sh [4] = '{`SHIFT_8, `SHIFT_10, `SHIFT_12, `SHIFT_16};
    sample_val <= 16'h0012;
    for (int k = 0; k < 4; k++) begin
      wr(`ADDR_CTRL, {21'h0, 2'(k), 1'b1});
      repeat (120) @(posedge mclk);
      rd(`ADDR_CUR_MEAS, v);
      chk(v, 24'(24'h00_0012 << sh[k]));
    end
    rd(`ADDR_VOLT_OUT, v);
    chk(v, 24'h00_0000);
  endtask

  // zero current against a saturated negative speed measurement drives phase a fully on
  task automatic t_full();
    logic [23:0] v;
    sample_val <= 16'h0000;
    wr(`ADDR_CUR_KP, 24'h7F_FFFF);
    repeat (1500) @(posedge mclk);
    rd(`ADDR_SPEED_MEAS, v);
    chk(v, 24'h80_0001);
    rd(`ADDR_VOLT_OUT, v);
    chk(v, `FRAC_MAX);
    for (int i = 0; i < 40; i++) begin
      @(posedge mclk);
      #1 chk({22'h0, phase_a, phase_b}, 24'h00_0002);
    end
  endtask

  task automatic t_disable();
    int hits;
    logic [23:0] v;
    wr(`ADDR_CTRL, 24'h00_0000);
    @(posedge mclk);
    hits = 0;
    for (int i = 0; i < 100; i++) begin
      @(posedge mclk);
      #1 if (conv_req !== 1'b0 || phase_a !== 1'b0 || phase_b !== 1'b0) hits++;
    end
    chk(24'(hits), 24'h00_0000);
    rd(`ADDR_VOLT_OUT, v);
    chk(v, 24'h00_0000);
  endtask

  task automatic final_report();
    $display("errors=%0d compares=%0d", n_errors, compares);
    if (n_errors == 0 && compares > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  initial begin
    #1_000_000;
    n_errors++;
    final_report();
  end

  initial begin
    rst_n = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 4'h0;
    reg_wdata = 24'h00_0000;
    hall_in = 3'h0;
    sample_val = 16'h0000;
    repeat (12) @(posedge mclk);
    rst_n <= 1'b1;
    t_reset();
    t_hall();
    t_enable();
    t_sample();
    t_full();
    t_disable();
    final_report();
  end
endmodule // dc_motor_cascade_loop_tb
`default_nettype wire
